// ===== cemsx_exec.v
// Summary of operation
// RULE1: Unsigned multiply into accumulator or data:accumulator
// RULE2: Product upper half sets carry, overflow
// RULE3: Negate replaces operand with zero minus it
// RULE4: Most negative operand unchanged, sets overflow
// RULE5: Negate updates six flags, carry if nonzero
// RULE6: Idle opcode changes nothing
// RULE7: Invert is one's complement, flags untouched
// RULE8: Or clears carry, overflow; sets parity sign zero
// RULE9: Or decodes register, immediate, accumulator forms
// RULE10: Port write of accumulator, immediate or data port
// RULE11: Fixed and variable port forms; low byte first
// RULE12: Stack read loads word, stack pointer plus two
// RULE13: Register and segment stack reads; code undefined
// RULE14: Flag restore loads defined flag bits, pointer plus two
// RULE15: Trap flag comes from bit eight
// RULE16: Undefined flags keep previous value
// RULE17: Stack read to code segment only sets undefined status
`include "cemsx_defines.vh"
module cemsx_exec
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire [6:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   output wire        io_req,
   output wire        io_we,
   output wire        io_space,
   output wire [15:0] io_addr,
   output wire [7:0]  io_wdata,
   input  wire [7:0]  io_rdata,
   input  wire        io_ack,
   output wire        busy
);
   localparam S_IDLE = 6'b000001;
   localparam S_RD   = 6'b000010;
   localparam S_EXEC = 6'b000100;
   localparam S_WR   = 6'b001000;
   localparam S_POP  = 6'b010000;
   localparam S_OUT  = 6'b100000;

   reg  [5:0]   state_q;
   reg  [15:0]  gpr_q [0:7];
   reg  [15:0]  seg_q [0:3];
   reg  [15:0]  flags_q;
   reg  [31:0]  instr_q;
   reg  [15:0]  ea_q;
   reg  [15:0]  mem_q;
   reg          undef_q;
   reg          rd_done_q;
   reg          bus_start_q;
   reg          bus_we_q;
   reg          bus_space_q;
   reg          bus_word_q;
   reg  [15:0]  bus_addr_q;
   reg  [15:0]  bus_wdata_q;
   reg  [31:0]  rd_mux;
   wire [15:0]  bus_rdata;
   wire         bus_done;
   wire [31:0]  alu_res;
   wire [15:0]  alu_flags;
   wire [127:0] gpr_flat;
   integer      i;

   function [15:0] rd_reg;
      input [127:0] flat;
      input [2:0]   r;
      input         w;
      reg   [15:0]  g;
      begin
         g = flat[{1'b0, r[1:0]} * 16 +: 16];
         if (w)
            rd_reg = flat[r * 16 +: 16];
         else
            rd_reg = {8'h00, r[2] ? g[15:8] : g[7:0]};
      end
   endfunction

   function [15:0] merge;
      input [15:0] old;
      input [15:0] val;
      input        hi;
      input        w;
      begin
         if (w)
            merge = val;
         else if (hi)
            merge = {val[7:0], old[7:0]};
         else
            merge = {old[15:8], val[7:0]};
      end
   endfunction

   assign gpr_flat = {gpr_q[7], gpr_q[6], gpr_q[5], gpr_q[4],
                      gpr_q[3], gpr_q[2], gpr_q[1], gpr_q[0]};

   wire [7:0]  opc  = instr_q[7:0];
   wire [1:0]  md   = instr_q[15:14];
   wire [2:0]  rg   = instr_q[13:11];
   wire [2:0]  rm   = instr_q[10:8];
   wire [15:0] imm  = instr_q[31:16];
   wire        w    = opc[0];
   wire        grp3 = (opc[7:1] == 7'b1111011);
   wire        do_mul = grp3 && (rg == 3'b100);
   wire        do_neg = grp3 && (rg == 3'b011);
   wire        do_not = grp3 && (rg == 3'b010);
   // RULE9: three or encodings
   wire        or_rm  = (opc[7:2] == 6'b000010);
   wire        or_imm = (opc[7:1] == 7'b1000000) && (rg == 3'b001);
   wire        or_acc = (opc[7:1] == 7'b0000110);
   // RULE11: fixed and variable port decode
   wire        out_fix = (opc[7:1] == 7'b1110011);
   wire        out_var = (opc[7:1] == 7'b1110111);
   // RULE13: register and segment stack read decode
   wire        pop_rm  = (opc == `CEMSX_OP_POPRM) && (rg == 3'b000);
   wire        pop_reg = (opc[7:3] == 5'b01011);
   wire        pop_seg = (opc[7:5] == 3'b000) && (opc[2:0] == 3'b111);
   wire        pop_cs  = pop_seg && (opc[4:3] == `CEMSX_SEG_CODE);
   wire        flag_restore_op    = (opc == `CEMSX_OP_FLAGREST);
   wire        is_alu  = do_mul | do_neg | do_not | or_rm | or_imm | or_acc;
   wire        use_ea  = do_mul | do_neg | do_not | or_rm | or_imm;
   wire        mem_ea  = (use_ea | pop_rm) && (md != 2'b11);
   wire        ea_dest = do_neg | do_not | or_imm | (or_rm & ~opc[1]);
   wire        op_w    = w;
   wire [15:0] acc     = rd_reg(gpr_flat, `CEMSX_IDX_ACC, op_w);
   wire [15:0] ea_val  = (md == 2'b11) ? rd_reg(gpr_flat, rm, op_w) : mem_q;
   wire [15:0] reg_val = rd_reg(gpr_flat, rg, op_w);
   wire [15:0] imm_val = op_w ? imm : {8'h00, imm[7:0]};
   wire [1:0]  alu_op  = do_mul ? `CEMSX_ALU_MUL :
                         do_neg ? `CEMSX_ALU_NEG :
                         do_not ? `CEMSX_ALU_NOT : `CEMSX_ALU_OR;
   wire [15:0] alu_a   = or_acc ? acc : (do_mul ? acc : ea_val);
   wire [15:0] alu_b   = or_rm ? (opc[1] ? ea_val : reg_val) :
                         (or_imm | or_acc) ? imm_val : ea_val;
   wire [15:0] or_a    = (or_rm & opc[1]) ? reg_val : alu_a;

   wire stall = busy && (avs_read || avs_write) &&
                (avs_address != `CEMSX_REG_STATUS);
   wire wr_ok = avs_write && !stall;
   wire rd_go = avs_read && !rd_done_q && !stall;
   wire start = wr_ok && (avs_address == `CEMSX_REG_CTRL) &&
                avs_writedata[`CEMSX_CTRL_START];

   assign busy = (state_q != S_IDLE);
   assign avs_waitrequest = stall || (avs_read && !rd_done_q);

   cemsx_alu u_alu
   (
      .op        (alu_op),
      .w         (op_w),
      .a         (or_a),
      .b         (alu_b),
      .flags_in  (flags_q),
      .result    (alu_res),
      .flags_out (alu_flags)
   );

   cemsx_bus u_bus
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .start    (bus_start_q),
      .we       (bus_we_q),
      .space    (bus_space_q),
      .word     (bus_word_q),
      .addr     (bus_addr_q),
      .wdata    (bus_wdata_q),
      .rdata    (bus_rdata),
      .done     (bus_done),
      .io_req   (io_req),
      .io_we    (io_we),
      .io_space (io_space),
      .io_addr  (io_addr),
      .io_wdata (io_wdata),
      .io_rdata (io_rdata),
      .io_ack   (io_ack)
   );

   // Register read decode
   always @*
   begin
      rd_mux = 32'h00000000;
      if (avs_address == `CEMSX_REG_CTRL)
         rd_mux = 32'h00000000;
      else if (avs_address == `CEMSX_REG_INSTR)
         rd_mux = instr_q;
      else if (avs_address == `CEMSX_REG_EA)
         rd_mux = {16'h0000, ea_q};
      else if (avs_address == `CEMSX_REG_STATUS)
         rd_mux = {30'h00000000, undef_q, busy};
      else if (avs_address == `CEMSX_REG_FLAGS)
         rd_mux = {16'h0000, flags_q};
      else if (avs_address >= `CEMSX_REG_GPR_BASE &&
               avs_address <= `CEMSX_REG_GPR_LAST &&
               avs_address[1:0] == 2'b00)
         rd_mux = {16'h0000, gpr_q[avs_address[4:2]]};
      else if (avs_address >= `CEMSX_REG_SEG_BASE &&
               avs_address <= `CEMSX_REG_SEG_LAST &&
               avs_address[1:0] == 2'b00)
         rd_mux = {16'h0000, seg_q[avs_address[3:2]]};
      else
         rd_mux = 32'h00000000;
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_q <= S_IDLE;
         for (i = 0; i < 8; i = i + 1)
            gpr_q[i] <= `CEMSX_GPR_RST;
         for (i = 0; i < 4; i = i + 1)
            seg_q[i] <= `CEMSX_GPR_RST;
         flags_q <= `CEMSX_FLAGS_RST;
         instr_q <= 32'h00000000;
         ea_q <= 16'h0000;
         mem_q <= 16'h0000;
         undef_q <= 1'b0;
         rd_done_q <= 1'b0;
         avs_readdata <= 32'h00000000;
         bus_start_q <= 1'b0;
         bus_we_q <= 1'b0;
         bus_space_q <= 1'b0;
         bus_word_q <= 1'b0;
         bus_addr_q <= 16'h0000;
         bus_wdata_q <= 16'h0000;
      end
      else
      begin
         bus_start_q <= 1'b0;
         rd_done_q <= rd_go;
         if (rd_go)
            avs_readdata <= rd_mux;
         // Software writes land only while idle, or on status
         if (wr_ok)
         begin
            if (avs_address == `CEMSX_REG_INSTR)
               instr_q <= avs_writedata;
            else if (avs_address == `CEMSX_REG_EA)
               ea_q <= avs_writedata[15:0];
            else if (avs_address == `CEMSX_REG_STATUS &&
                     avs_writedata[`CEMSX_STAT_UNDEF])
               undef_q <= 1'b0;
            else if (avs_address == `CEMSX_REG_FLAGS)
               flags_q <= avs_writedata[15:0] & `CEMSX_FLAGS_MASK;
            else if (avs_address >= `CEMSX_REG_GPR_BASE &&
                     avs_address <= `CEMSX_REG_GPR_LAST &&
                     avs_address[1:0] == 2'b00)
               gpr_q[avs_address[4:2]] <= avs_writedata[15:0];
            else if (avs_address >= `CEMSX_REG_SEG_BASE &&
                     avs_address <= `CEMSX_REG_SEG_LAST &&
                     avs_address[1:0] == 2'b00)
               seg_q[avs_address[3:2]] <= avs_writedata[15:0];
         end
         case (state_q)
            S_IDLE:
               if (start)
               begin
                  if (pop_cs)
                  begin
                     // RULE17: code segment stack read is dropped
                     undef_q <= 1'b1;
                  end
                  else if (pop_rm || pop_reg || pop_seg || flag_restore_op)
                  begin
                     // RULE12: word read at stack pointer
                     bus_start_q <= 1'b1;
                     bus_we_q <= 1'b0;
                     bus_space_q <= 1'b0;
                     bus_word_q <= 1'b1;
                     bus_addr_q <= gpr_q[`CEMSX_IDX_SP];
                     state_q <= S_POP;
                  end
                  else if (out_fix || out_var)
                  begin
                     // RULE10: accumulator to port
                     bus_start_q <= 1'b1;
                     bus_we_q <= 1'b1;
                     bus_space_q <= 1'b1;
                     bus_word_q <= op_w;
                     bus_addr_q <= out_fix ? {8'h00, imm[7:0]}
                                           : gpr_q[`CEMSX_IDX_DX];
                     bus_wdata_q <= acc;
                     state_q <= S_OUT;
                  end
                  else if (is_alu && mem_ea)
                  begin
                     bus_start_q <= 1'b1;
                     bus_we_q <= 1'b0;
                     bus_space_q <= 1'b0;
                     bus_word_q <= op_w;
                     bus_addr_q <= ea_q;
                     state_q <= S_RD;
                  end
                  else if (is_alu)
                     state_q <= S_EXEC;
                  // RULE6: idle and foreign opcodes leave state alone
               end
            S_RD:
               if (bus_done)
               begin
                  mem_q <= bus_rdata;
                  state_q <= S_EXEC;
               end
            S_EXEC:
            begin
               state_q <= S_IDLE;
               flags_q <= alu_flags;
               if (do_mul)
               begin
                  // RULE1: product to accumulator, and high word to data word for word form
                  gpr_q[`CEMSX_IDX_ACC] <= alu_res[15:0];
                  if (op_w)
                     gpr_q[`CEMSX_IDX_DX] <= alu_res[31:16];
               end
               else if (or_acc)
                  gpr_q[`CEMSX_IDX_ACC] <= merge(gpr_q[`CEMSX_IDX_ACC],
                                                 alu_res[15:0], 1'b0, op_w);
               else if (or_rm && opc[1])
                  // RULE9: direction bit picks register destination
                  gpr_q[op_w ? rg : {1'b0, rg[1:0]}] <=
                     merge(gpr_q[op_w ? rg : {1'b0, rg[1:0]}],
                           alu_res[15:0], rg[2], op_w);
               else if (ea_dest && md == 2'b11)
                  gpr_q[op_w ? rm : {1'b0, rm[1:0]}] <=
                     merge(gpr_q[op_w ? rm : {1'b0, rm[1:0]}],
                           alu_res[15:0], rm[2], op_w);
               else if (ea_dest)
               begin
                  bus_start_q <= 1'b1;
                  bus_we_q <= 1'b1;
                  bus_space_q <= 1'b0;
                  bus_word_q <= op_w;
                  bus_addr_q <= ea_q;
                  bus_wdata_q <= alu_res[15:0];
                  state_q <= S_WR;
               end
            end
            S_WR:
               if (bus_done)
                  state_q <= S_IDLE;
            S_POP:
               if (bus_done)
               begin
                  state_q <= S_IDLE;
                  // RULE12: stack pointer advances by two
                  gpr_q[`CEMSX_IDX_SP] <= gpr_q[`CEMSX_IDX_SP] +
                                          `CEMSX_STACK_STEP;
                  if (flag_restore_op)
                     // RULE14: defined bits only
                     // RULE15: trap from bit eight
                     flags_q <= bus_rdata & `CEMSX_FLAGS_MASK;
                  else if (pop_reg)
                     gpr_q[opc[2:0]] <= bus_rdata;
                  else if (pop_seg)
                     seg_q[opc[4:3]] <= bus_rdata;
                  else if (md == 2'b11)
                     gpr_q[rm] <= bus_rdata;
                  else
                  begin
                     bus_start_q <= 1'b1;
                     bus_we_q <= 1'b1;
                     bus_space_q <= 1'b0;
                     bus_word_q <= 1'b1;
                     bus_addr_q <= ea_q;
                     bus_wdata_q <= bus_rdata;
                     state_q <= S_WR;
                  end
               end
            S_OUT:
               if (bus_done)
                  state_q <= S_IDLE;
            default:
               state_q <= S_IDLE;
         endcase
      end
   end
endmodule

// ===== cemsx_defines.vh
`ifndef CEMSX_DEFINES_VH
`define CEMSX_DEFINES_VH
// Register byte offsets on the Avalon slave
`define CEMSX_REG_CTRL     7'h00
`define CEMSX_REG_INSTR    7'h04
`define CEMSX_REG_EA       7'h08
`define CEMSX_REG_STATUS   7'h0c
`define CEMSX_REG_FLAGS    7'h10
`define CEMSX_REG_GPR_BASE 7'h20
`define CEMSX_REG_GPR_LAST 7'h3c
`define CEMSX_REG_SEG_BASE 7'h40
`define CEMSX_REG_SEG_LAST 7'h4c
// Control and status bits
`define CEMSX_CTRL_START   0
`define CEMSX_STAT_BUSY    0
`define CEMSX_STAT_UNDEF   1
// Flag bit positions
`define CEMSX_F_CARRY      0
`define CEMSX_F_PARITY     2
`define CEMSX_F_AUX        4
`define CEMSX_F_ZERO       6
`define CEMSX_F_SIGN       7
`define CEMSX_F_TRAP       8
`define CEMSX_F_OVER       11
`define CEMSX_FLAGS_MASK   16'h0fd5
`define CEMSX_FLAGS_RST    16'h0000
`define CEMSX_GPR_RST      16'h0000
// Register file indices
`define CEMSX_IDX_ACC      3'h0
`define CEMSX_IDX_DX       3'h2
`define CEMSX_IDX_SP       3'h4
`define CEMSX_SEG_CODE     2'h1
`define CEMSX_STACK_STEP   16'h0002
// Opcodes
`define CEMSX_OP_IDLE      8'h90
`define CEMSX_OP_POPRM     8'h8f
`define CEMSX_OP_FLAGREST  8'h9c
// Arithmetic unit operations
`define CEMSX_ALU_MUL      2'h0
`define CEMSX_ALU_NEG      2'h1
`define CEMSX_ALU_NOT      2'h2
`define CEMSX_ALU_OR       2'h3
`endif

// ===== cemsx_alu.v
`include "cemsx_defines.vh"
module cemsx_alu
(
   input  wire [1:0]  op,
   input  wire        w,
   input  wire [15:0] a,
   input  wire [15:0] b,
   input  wire [15:0] flags_in,
   output reg  [31:0] result,
   output reg  [15:0] flags_out
);
   reg  [15:0] r16;
   reg         msb;
   always @*
   begin
      result = 32'h00000000;
      flags_out = flags_in;
      r16 = 16'h0000;
      msb = 1'b0;
      case (op)
         `CEMSX_ALU_MUL:
         begin
            // RULE1: unsigned byte or word product
            if (w)
               result = a * b;
            else
               result = {16'h0000, {8'h00, a[7:0]} * {8'h00, b[7:0]}};
            // RULE2: upper half sets carry and overflow
            flags_out[`CEMSX_F_CARRY] = w ? (result[31:16] != 16'h0000)
                                          : (result[15:8] != 8'h00);
            flags_out[`CEMSX_F_OVER] = flags_out[`CEMSX_F_CARRY];
            // RULE16: undefined flags keep value
         end
         `CEMSX_ALU_NEG:
         begin
            // RULE3: zero minus operand
            r16 = 16'h0000 - a;
            if (!w)
               r16[15:8] = 8'h00;
            result = {16'h0000, r16};
            msb = w ? r16[15] : r16[7];
            // RULE4: most negative value flags overflow
            flags_out[`CEMSX_F_OVER] = w ? (a == 16'h8000) : (a[7:0] == 8'h80);
            // RULE5: carry set unless operand zero
            flags_out[`CEMSX_F_CARRY] = w ? (a != 16'h0000) : (a[7:0] != 8'h00);
            flags_out[`CEMSX_F_AUX] = (a[3:0] != 4'h0);
            flags_out[`CEMSX_F_PARITY] = ~^r16[7:0];
            flags_out[`CEMSX_F_SIGN] = msb;
            flags_out[`CEMSX_F_ZERO] = (r16 == 16'h0000);
         end
         `CEMSX_ALU_NOT:
         begin
            // RULE7: all-ones minus operand, flags kept
            r16 = (w ? 16'hffff : 16'h00ff) - (w ? a : {8'h00, a[7:0]});
            result = {16'h0000, r16};
         end
         default:
         begin
            // RULE8: inclusive or with logic flags
            r16 = w ? (a | b) : {8'h00, a[7:0] | b[7:0]};
            result = {16'h0000, r16};
            msb = w ? r16[15] : r16[7];
            flags_out[`CEMSX_F_CARRY] = 1'b0;
            flags_out[`CEMSX_F_OVER] = 1'b0;
            flags_out[`CEMSX_F_PARITY] = ~^r16[7:0];
            flags_out[`CEMSX_F_SIGN] = msb;
            flags_out[`CEMSX_F_ZERO] = (r16 == 16'h0000);
         end
      endcase
   end
endmodule

// ===== cemsx_bus.v
`include "cemsx_defines.vh"
module cemsx_bus
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire        start,
   input  wire        we,
   input  wire        space,
   input  wire        word,
   input  wire [15:0] addr,
   input  wire [15:0] wdata,
   output reg  [15:0] rdata,
   output reg         done,
   output reg         io_req,
   output reg         io_we,
   output reg         io_space,
   output reg  [15:0] io_addr,
   output reg  [7:0]  io_wdata,
   input  wire [7:0]  io_rdata,
   input  wire        io_ack
);
   localparam S_IDLE = 4'b0001;
   localparam S_LO   = 4'b0010;
   localparam S_GAP  = 4'b0100;
   localparam S_HI   = 4'b1000;
   reg [3:0]  state_q;
   reg [7:0]  hi_q;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_q <= S_IDLE;
         rdata <= 16'h0000;
         done <= 1'b0;
         io_req <= 1'b0;
         io_we <= 1'b0;
         io_space <= 1'b0;
         io_addr <= 16'h0000;
         io_wdata <= 8'h00;
         hi_q <= 8'h00;
      end
      else
      begin
         done <= 1'b0;
         case (state_q)
            S_IDLE:
               if (start)
               begin
                  io_req <= 1'b1;
                  io_we <= we;
                  io_space <= space;
                  io_addr <= addr;
                  io_wdata <= wdata[7:0];
                  hi_q <= wdata[15:8];
                  state_q <= word ? S_LO : S_HI;
               end
            S_LO:
               // RULE11: low byte first, then address plus one
               if (io_ack)
               begin
                  io_req <= 1'b0;
                  rdata[7:0] <= io_rdata;
                  state_q <= S_GAP;
               end
            S_GAP:
            begin
               io_req <= 1'b1;
               io_addr <= io_addr + 16'h0001;
               io_wdata <= hi_q;
               state_q <= S_HI;
            end
            default:
               if (io_ack)
               begin
                  io_req <= 1'b0;
                  if (io_addr == addr)
                     rdata <= {8'h00, io_rdata};
                  else
                     rdata[15:8] <= io_rdata;
                  done <= 1'b1;
                  state_q <= S_IDLE;
               end
         endcase
      end
   end
endmodule

// ===== cemsx_mem_model.sv
module cemsx_mem_model
(
   input  wire        clk,
   input  wire        io_req,
   input  wire        io_we,
   input  wire        io_space,
   input  wire [15:0] io_addr,
   input  wire [7:0]  io_wdata,
   input  wire [1:0]  lat,
   output logic [7:0] io_rdata,
   output logic       io_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   logic [7:0] port [0:65535];
   logic [1:0] wait_q = 2'h0;
   initial
   begin
      io_ack = 1'b0;
      io_rdata = 8'h00;
   end
   // Byte served after lat idle cycles; data line churns when idle
   always @(posedge clk)
   begin
      io_ack <= 1'b0;
      io_rdata <= ~io_rdata;
      if (io_req && !io_ack)
      begin
         wait_q <= wait_q + 2'h1;
         if (wait_q == lat)
         begin
            wait_q <= 2'h0;
            io_ack <= 1'b1;
            if (io_we && io_space)
               port[io_addr] <= io_wdata;
            else if (io_we)
               mem[io_addr] <= io_wdata;
            else
               io_rdata <= mem[io_addr];
         end
      end
   end
endmodule

// ===== cemsx_exec_checker.sv
module cemsx_checker
(
   input wire        clk,
   input wire        rst_n,
   input wire        avs_read,
   input wire        avs_write,
   input wire        avs_waitrequest,
   input wire        io_req,
   input wire        io_we,
   input wire        io_space,
   input wire [15:0] io_addr,
   input wire [7:0]  io_wdata,
   input wire        io_ack,
   input wire        busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rd_mem;
      io_req && !io_we |-> !io_space;
   endproperty
   a_rd_mem: assert property (p_rd_mem) else $error("read in port space");
   property p_wr_hi;
      (io_ack && io_we) ##1 !io_req ##1 (io_req && io_we)
         |-> io_addr == $past(io_addr, 2) + 16'h0001;
   endproperty
   a_wr_hi: assert property (p_wr_hi) else $error("high byte address");
   property p_rd_hi;
      (io_ack && !io_we) ##1 !io_req ##1 (io_req && !io_we)
         |-> io_addr == $past(io_addr, 2) + 16'h0001;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("stack high byte");
   property p_hold;
      io_req && !io_ack |=> io_req && $stable(io_addr) && $stable(io_wdata);
   endproperty
   a_hold: assert property (p_hold) else $error("byte request moved");
   property p_drop;
      io_ack |=> !io_req;
   endproperty
   a_drop: assert property (p_drop) else $error("request after ack");
   property p_idle;
      !busy |-> !io_req;
   endproperty
   a_idle: assert property (p_idle) else $error("bus used when idle");
   property p_end;
      $rose(busy) |-> ##[1:60] !busy;
   endproperty
   a_end: assert property (p_end) else $error("busy too long");
   property p_rd_wait;
      $rose(avs_read) && !busy |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read latency");
   c_port: cover property (io_ack && io_we && io_space);
   c_load: cover property (io_ack && !io_we);
   c_done: cover property ($fell(busy));
endmodule
bind cemsx_exec cemsx_checker u_chk (.*);

// ===== cemsx_tb.sv
`include "cemsx_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] r_acc = 7'h20, r_cnt = 7'h24, r_dat = 7'h28;
   localparam logic [6:0] r_stk = 7'h30, r_flg = 7'h10;
   logic        clk;
   logic        rst_n;
   logic        avs_read;
   logic        avs_write;
   logic [6:0]  avs_address;
   logic [31:0] avs_writedata;
   logic [1:0]  lat;
   logic [31:0] rd;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest, io_req, io_we, io_space, io_ack, busy;
   wire  [15:0] io_addr;
   wire  [7:0]  io_wdata, io_rdata;
   int          mismatches;
   int          n_checks;
   logic [7:0]  or_op [3] = '{8'h0b, 8'h81, 8'h0d};
   logic [7:0]  or_mr [3] = '{8'hc1, 8'hc8, 8'h00};
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: %h not %h", $time, g, e); end end
   cemsx_exec u_dut (.*);
   cemsx_mem_model u_mem (.*);
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic ck(input logic [6:0] a, input logic [15:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rd[15:0], e)
   endtask
   task automatic run(input logic [7:0] op, mr, input logic [15:0] im);
      bus(1'b1, `CEMSX_REG_INSTR, {im, mr, op});
      bus(1'b1, `CEMSX_REG_CTRL, 32'h1);
      rd = 32'h1;
      for (int k = 0; k < 200 && rd[0] !== 1'b0; k++)
         bus(1'b0, `CEMSX_REG_STATUS, 32'h0);
      if (rd[0] !== 1'b0)
         mismatches++;
   endtask
   task automatic mw(input logic [15:0] a, input logic [15:0] d);
      u_mem.mem[a] = d[7:0];
      u_mem.mem[a + 16'h0001] = d[15:8];
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end
   initial
   begin
      {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {lat, mismatches, n_checks} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b1, 7'h50, 32'h1234);
      ck(7'h50, 16'h0000);
      bus(1'b1, r_flg, 32'h00c0);
      bus(1'b1, r_acc, 32'h1210);
      bus(1'b1, r_cnt, 32'h0024);
      run(8'hf6, 8'he1, 16'h0);
      ck(r_acc, 16'h0240);
      ck(r_flg, 16'h08c1);
      bus(1'b1, r_dat, 32'hffff);
      bus(1'b1, r_cnt, 32'h0004);
      run(8'hf7, 8'he1, 16'h0);
      ck(r_acc, 16'h0900);
      ck(r_dat, 16'h0000);
      ck(r_flg, 16'h00c0);
      bus(1'b1, r_acc, 32'h8000);
      run(8'hf7, 8'hd8, 16'h0);
      ck(r_acc, 16'h8000);
      ck(r_flg, 16'h0885);
      bus(1'b1, r_acc, 32'h0000);
      run(8'hf7, 8'hd8, 16'h0);
      ck(r_flg, 16'h0044);
      bus(1'b1, r_acc, 32'h3401);
      run(8'hf6, 8'hd8, 16'h0);
      ck(r_acc, 16'h34ff);
      ck(r_flg, 16'h0095);
      run(8'hf7, 8'hd0, 16'h0);
      ck(r_acc, 16'hcb00);
      ck(r_flg, 16'h0095);
      lat <= 2'h3;
      mw(16'h0200, 16'hf00f);
      bus(1'b1, `CEMSX_REG_EA, 32'h0200);
      run(8'hf7, 8'h17, 16'h0);
      `CHK(u_mem.mem[16'h0201], 8'h0f)
      for (int i = 0; i < 3; i++)
      begin
         bus(1'b1, r_flg, 32'h0811);
         bus(1'b1, r_acc, 32'h1200);
         bus(1'b1, r_cnt, 32'h0034);
         run(or_op[i], or_mr[i], 16'h0034);
         ck(r_acc, 16'h1234);
         ck(r_flg, 16'h0010);
      end
      bus(1'b1, r_acc, 32'ha55a);
      run(8'he7, 8'h00, 16'h0044);
      `CHK(u_mem.port[16'h0045], 8'ha5)
      bus(1'b1, r_dat, 32'hfffe);
      lat <= 2'h0;
      run(8'hee, 8'h00, 16'h0);
      `CHK(u_mem.port[16'hfffe], 8'h5a)
      bus(1'b1, r_stk, 32'h0100);
      mw(16'h0100, 16'h1234);
      mw(16'h0102, 16'h0100);
      mw(16'h0104, 16'hffff);
      mw(16'h0106, 16'habcd);
      run(8'h59, 8'h00, 16'h0);
      ck(r_cnt, 16'h1234);
      run(8'h9c, 8'h00, 16'h0);
      ck(r_flg, 16'h0100);
      run(8'h9c, 8'h00, 16'h0);
      ck(r_flg, 16'h0fd5);
      run(8'h0f, 8'h00, 16'h0);
      ck(`CEMSX_REG_STATUS, 16'h0002);
      bus(1'b1, `CEMSX_REG_STATUS, 32'h2);
      ck(`CEMSX_REG_STATUS, 16'h0000);
      run(8'h1f, 8'h00, 16'h0);
      ck(`CEMSX_REG_SEG_LAST, 16'habcd);
      run(8'h90, 8'h00, 16'h0);
      ck(r_stk, 16'h0108);
      mw(16'h0108, 16'h5678);
      run(8'h8f, 8'hc3, 16'h0);
      ck(7'h2c, 16'h5678);
      ck(r_stk, 16'h010a);
      close_out();
   end
endmodule
